/* File: core/dicc_top.sv */
// Contract
// - Toggle rise closes side A integrate switches
// - Toggle fall: B integrates, A held converted
// - Convert held side while other integrates
// - After each four conversions, reference-charge that group; idle after the sixteenth
// - Load shift register, drop result ready
// - One range setting for all integrators
// - Range 00/01/10 picks 0.75/1.5/3 pF
// - Word length 16, 14 or 12 bits
// - Truncate low bits for shorter words
// - Straight binary, zero input gives 0492h
// - Saturate at all ones and zeros
// - Config input captured on clock falling edges
// - Result ready changes on clock falling edge
// - Readback puts config bit 15 first
// - Serial output advances on shift clock fall
// - Ready returns high after first shift fall
// - Toggle low means B, high means A
// - Most significant bit shifted out first
// - Range 11 behaves as range 10
// - Resolution 00=16, 01=14, else 12 bits
`timescale 1ns/1ns
`default_nettype none
module dicc_top (
    // Clocks and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    shift_clk,
    // Host control
    input  wire logic                    side_toggle,
    input  wire logic                    cfg_din,
    input  wire logic                    cfg_write_en,
    // Serial readout
    output logic                         result_ready_n,
    output logic                         serial_out_lane1,
    // Front-end switches
    output logic [15:0]                  side_a_integrate_switch,
    output logic [15:0]                  side_b_integrate_switch,
    output logic [15:0]                  reference_connect_switch,
    output logic [15:0]                  capacitor_clear_switch,
    output logic [2:0]                   feedback_capacitor,
    output logic [1:0]                   output_word_length_sel,
    // Converter
    output dicc_pkg::dicc_adc_req_t      adc_req,
    input  wire logic                    adc_done,
    input  wire logic signed [16:0]      adc_value
);
    // ****************************************
    // Functions
    // ****************************************
    function automatic int word_bits(input logic [1:0] r);
        case (r)
            dicc_pkg::RES_16: word_bits = 16;
            dicc_pkg::RES_14: word_bits = 14;
            default:          word_bits = 12;
        endcase
    endfunction : word_bits

    // Offset binary with clamping
    function automatic logic [15:0] to_code(input logic signed [16:0] v);
        logic signed [18:0] s;
        s = 19'(v) + 19'(signed'({3'h0, dicc_pkg::ZERO_CODE}));
        if (s < 0)
            to_code = dicc_pkg::CODE_MIN;
        else if (s > 19'(signed'({3'h0, dicc_pkg::CODE_MAX})))
            to_code = dicc_pkg::CODE_MAX;
        else
            to_code = s[15:0];
    endfunction : to_code

    // Channel 0 leads, each word MSB first, left aligned
    function automatic logic [255:0] pack(input logic [15:0][15:0] w,
                                          input logic [1:0] r);
        logic [255:0] a;
        int           n;
        a = '0;
        n = word_bits(r);
        for (int i = 0; i < dicc_pkg::N_CH; i++) begin
            a = (a << n) | 256'(w[i] >> (16 - n));
        end
        pack = a << (256 - 16 * n);
    endfunction : pack

    // ****************************************
    // Reset and input synchronisers
    // ****************************************
    logic       rst_m_q;
    logic       rst_sync_n;
    logic [1:0] tog_sync_q;
    logic       tog_prev_q;
    logic [1:0] started_sync_q;
    logic       started_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_m_q    <= 1'b1;
            rst_sync_n <= rst_m_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tog_sync_q     <= 2'h0;
            tog_prev_q     <= 1'b0;
            started_sync_q <= 2'h0;
        end else begin
            tog_sync_q     <= {tog_sync_q[0], side_toggle};
            tog_prev_q     <= tog_sync_q[1];
            started_sync_q <= {started_sync_q[0], started_q};
        end
    end

    logic tog_s;
    logic tog_edge;
    assign tog_s    = tog_sync_q[1];
    assign tog_edge = tog_s ^ tog_prev_q;

    // ****************************************
    // Configuration, captured on falling edges
    // ****************************************
    dicc_pkg::dicc_cfg_t cfg_q, cfg_d;
    logic [15:0]         cfg_sh_q, cfg_sh_d;
    logic                cfg_wr_q, cfg_tog_q, cfg_tog_d;

    always_comb begin
        cfg_sh_d  = cfg_sh_q;
        cfg_d     = cfg_q;
        cfg_tog_d = cfg_tog_q;
        if (cfg_write_en)
            cfg_sh_d = {cfg_sh_q[14:0], cfg_din};
        if (cfg_wr_q && !cfg_write_en) begin
            cfg_d     = cfg_sh_q;
            cfg_tog_d = ~cfg_tog_q;
        end
    end

    always_ff @(negedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_sh_q  <= 16'h0000;
            cfg_q     <= dicc_pkg::CFG_RST;
            cfg_wr_q  <= 1'b0;
            cfg_tog_q <= 1'b0;
        end else begin
            cfg_sh_q  <= cfg_sh_d;
            cfg_q     <= cfg_d;
            cfg_wr_q  <= cfg_write_en;
            cfg_tog_q <= cfg_tog_d;
        end
    end

    // Range decode is shared by every channel and both sides
    always_comb begin
        case (cfg_q.range)
            dicc_pkg::RNG_3PC: feedback_capacitor = dicc_pkg::CAP_0P75PF;
            dicc_pkg::RNG_6PC: feedback_capacitor = dicc_pkg::CAP_1P5PF;
            default:           feedback_capacitor = dicc_pkg::CAP_3PF;
        endcase
    end
    assign output_word_length_sel = cfg_q.res;

    // ****************************************
    // Conversion sequencer
    // ****************************************
    dicc_pkg::dicc_state_t   st_q, st_d;
    logic [3:0]              ch_q, ch_d;
    logic [7:0]              cnt_q, cnt_d;
    logic                    held_a_q, held_a_d;
    logic [15:0][15:0]       res_q, res_d;
    logic [255:0]            frame_q, frame_d;
    logic                    arm_q, arm_d, pub_q, pub_d;
    logic                    cfg_seen_q, cfg_seen_d;
    logic [15:0]             last_code_q, last_code_d;
    logic [15:0]             int_a_q, int_a_d, grp_q, grp_d;
    dicc_pkg::dicc_adc_req_t req_q, req_d;

    always_comb begin
        st_d        = st_q;
        ch_d        = ch_q;
        cnt_d       = cnt_q;
        held_a_d    = held_a_q;
        res_d       = res_q;
        frame_d     = frame_q;
        arm_d       = 1'b0;
        pub_d       = 1'b0;
        cfg_seen_d  = cfg_seen_q;
        last_code_d = last_code_q;
        int_a_d     = {16{tog_s}};
        grp_d       = 16'h0000;
        req_d       = '0;
        req_d.side_a  = held_a_q;
        req_d.channel = ch_q;
        case (st_q)
            dicc_pkg::S_IDLE: begin
                if (cfg_seen_q != cfg_tog_q) begin
                    cfg_seen_d = cfg_tog_q;
                    frame_d    = {cfg_q, 240'h0};
                    cnt_d      = 8'h00;
                    st_d       = dicc_pkg::S_PUB;
                end
            end
            dicc_pkg::S_REQ: begin
                req_d.start = 1'b1;
                st_d        = dicc_pkg::S_WAIT;
            end
            dicc_pkg::S_WAIT: begin
                if (adc_done) begin
                    last_code_d = to_code(adc_value);
                    res_d[ch_q] = to_code(adc_value);
                    if (ch_q[1:0] == 2'(dicc_pkg::GROUP - 1)) begin
                        cnt_d = 8'h00;
                        st_d  = dicc_pkg::S_RST;
                    end else begin
                        ch_d = ch_q + 4'h1;
                        st_d = dicc_pkg::S_REQ;
                    end
                end
            end
            dicc_pkg::S_RST: begin
                grp_d = 16'h000F << {ch_q[3:2], 2'h0};
                cnt_d = cnt_q + 8'h01;
                // Last counted cycle keeps the group on the reference, so it sees the full count
                if (cnt_q == dicc_pkg::REF_CHARGE_CYC - 8'h01) begin
                    if (ch_q == 4'hF) begin
                        frame_d = pack(res_q, cfg_q.res);
                        cnt_d   = 8'h00;
                        st_d    = dicc_pkg::S_PUB;
                    end else begin
                        ch_d = ch_q + 4'h1;
                        st_d = dicc_pkg::S_REQ;
                    end
                end
            end
            dicc_pkg::S_PUB: begin
                // Clear the link side first so a stale start flag is gone
                arm_d = (cnt_q == 8'h00);
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == dicc_pkg::PUB_WAIT_CYC) begin
                    pub_d = 1'b1;
                    st_d  = dicc_pkg::S_IDLE;
                end
            end
            default: st_d = dicc_pkg::S_IDLE;
        endcase
        // A new phase abandons any unfinished conversion sweep
        if (tog_edge) begin
            held_a_d = ~tog_s;
            ch_d     = 4'h0;
            grp_d    = 16'h0000;
            st_d     = dicc_pkg::S_REQ;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_q        <= dicc_pkg::S_IDLE;
            ch_q        <= 4'h0;
            cnt_q       <= 8'h00;
            held_a_q    <= 1'b0;
            res_q       <= '0;
            frame_q     <= '0;
            arm_q       <= 1'b0;
            pub_q       <= 1'b0;
            cfg_seen_q  <= 1'b0;
            last_code_q <= 16'h0000;
            int_a_q     <= 16'h0000;
            grp_q       <= 16'h0000;
            req_q       <= '0;
        end else begin
            st_q        <= st_d;
            ch_q        <= ch_d;
            cnt_q       <= cnt_d;
            held_a_q    <= held_a_d;
            res_q       <= res_d;
            frame_q     <= frame_d;
            arm_q       <= arm_d;
            pub_q       <= pub_d;
            cfg_seen_q  <= cfg_seen_d;
            last_code_q <= last_code_d;
            int_a_q     <= int_a_d;
            grp_q       <= grp_d;
            req_q       <= req_d;
        end
    end

    assign side_a_integrate_switch  = int_a_q;
    assign side_b_integrate_switch  = ~int_a_q;
    assign reference_connect_switch = grp_q;
    assign capacitor_clear_switch   = grp_q;
    assign adc_req                  = req_q;

    // ****************************************
    // Result ready, on master clock falling edge
    // ****************************************
    logic rdy_n_q, rdy_n_d;

    always_comb begin
        rdy_n_d = rdy_n_q;
        if (pub_q)
            rdy_n_d = 1'b0;
        else if (started_sync_q[1] && !rdy_n_q)
            rdy_n_d = 1'b1;
    end

    always_ff @(negedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n)
            rdy_n_q <= 1'b1;
        else
            rdy_n_q <= rdy_n_d;
    end
    assign result_ready_n = rdy_n_q;

    // ****************************************
    // Link side, on shift clock falling edge
    // ****************************************
    // Shift clock may stand still, so the sequencer clears it directly
    logic       link_clr;
    logic [7:0] pos_q, pos_d;
    assign link_clr = ~rst_sync_n | arm_q;
    assign pos_d    = pos_q + 8'h01;

    always_ff @(negedge shift_clk or posedge link_clr) begin
        if (link_clr) begin
            pos_q     <= 8'h00;
            started_q <= 1'b0;
        end else begin
            pos_q     <= pos_d;
            started_q <= 1'b1;
        end
    end
    // Frame is stable while it is read out
    assign serial_out_lane1 = frame_q[8'hFF - pos_q];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    property p_side_a_rise;
        $rose(tog_s) |=> side_a_integrate_switch == 16'hFFFF;
    endproperty
    a_side_a_rise: assert property (p_side_a_rise) else $error("side A not integrating");
    property p_side_b_fall;
        $fell(tog_s) |=> side_b_integrate_switch == 16'hFFFF ##1 adc_req.side_a;
    endproperty
    a_side_b_fall: assert property (p_side_b_fall) else $error("side B or held A wrong");
    property p_level_map;
        side_a_integrate_switch == {16{$past(tog_s)}};
    endproperty
    a_level_map: assert property (p_level_map) else $error("side level mapping");
    property p_side_toggle_start;
        tog_edge |-> ##[2:2] (adc_req.start && adc_req.channel == 4'h0);
    endproperty
    a_side_toggle_start: assert property (p_side_toggle_start) else $error("no conversion start");
    property p_group_reset;
        (st_q == dicc_pkg::S_WAIT && adc_done && ch_q[1:0] == 2'h3 && !tog_edge)
            |=> ##1 capacitor_clear_switch != 16'h0000;
    endproperty
    a_group_reset: assert property (p_group_reset) else $error("no reset after group");
    property p_ready_low;
        pub_q |-> ##1 !result_ready_n;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready did not fall");
    property p_range_big;
        cfg_q.range[1] |-> feedback_capacitor == dicc_pkg::CAP_3PF;
    endproperty
    a_range_big: assert property (p_range_big) else $error("range 1x decode");
    property p_saturate;
        (st_q == dicc_pkg::S_WAIT && adc_done && adc_value > 17'sh0FB6D)
            |=> last_code_q == 16'hFFFF;
    endproperty
    a_saturate: assert property (p_saturate) else $error("no saturation");
    property p_zero_code;
        (st_q == dicc_pkg::S_WAIT && adc_done && adc_value == 17'sh0)
            |=> last_code_q == 16'h0492;
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero offset code");
    property p_ready_high;
        (!result_ready_n && started_sync_q[1] && !pub_q) |-> ##1 result_ready_n;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready stuck low");
    property p_shift_step;
        @(negedge shift_clk) disable iff (link_clr)
            started_q |-> pos_q == $past(pos_q) + 8'h01;
    endproperty
    a_shift_step: assert property (p_shift_step) else $error("shift not advancing");

    c_frame: cover property (st_q == dicc_pkg::S_RST && ch_q == 4'hF ##[1:40] pub_q);
    c_readback: cover property (cfg_seen_q != cfg_tog_q ##[1:8] !result_ready_n);
    c_shift_out: cover property (!result_ready_n ##[1:8] result_ready_n);
endmodule : dicc_top
`default_nettype wire

/* File: include/dicc_pkg.sv */
`default_nettype none
package dicc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    // Time the held capacitor stays on the reference before it floats
    localparam int T_REF_CHARGE_NS = 1000;
    localparam logic [7:0] REF_CHARGE_CYC =
        8'((T_REF_CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Cycles for the link side to see its clear before ready falls
    localparam logic [7:0] PUB_WAIT_CYC = 8'h03;

    // ****************************************
    // Geometry and codes
    // ****************************************
    localparam int N_CH = 16;
    localparam int GROUP = 4;
    localparam logic [15:0] ZERO_CODE = 16'h0492;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;
    localparam logic [15:0] CODE_MIN = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0100;
    localparam logic [1:0] RES_16 = 2'h0;
    localparam logic [1:0] RES_14 = 2'h1;
    localparam logic [1:0] RNG_3PC = 2'h0;
    localparam logic [1:0] RNG_6PC = 2'h1;
    // One-hot feedback capacitor selects
    localparam logic [2:0] CAP_0P75PF = 3'h1;
    localparam logic [2:0] CAP_1P5PF = 3'h2;
    localparam logic [2:0] CAP_3PF = 3'h4;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic       one;
        logic       mode;
        logic [1:0] res;
        logic [1:0] range;
        logic       zero9;
        logic       hi_speed;
        logic [1:0] tm;
        logic       zero5;
        logic       bufdis;
        logic [3:0] zero_lo;
    } dicc_cfg_t;

    typedef struct packed {
        logic       start;
        logic       side_a;
        logic [3:0] channel;
    } dicc_adc_req_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_REQ  = 5'h02,
        S_WAIT = 5'h04,
        S_RST  = 5'h08,
        S_PUB  = 5'h10
    } dicc_state_t;
endpackage : dicc_pkg
`default_nettype wire

/* File: tb/dicc_adc_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dicc_adc_model (
    // Clock
    input  wire logic                    clk,
    // Request from the sequencer
    input  wire dicc_pkg::dicc_adc_req_t req,
    input  wire logic                    slow,
    // Answer
    output logic                         done,
    output logic signed [16:0]           value
);
    logic               busy;
    logic [3:0]         cnt;
    logic signed [16:0] held;

    // ****************************************
    // Per-channel charge, picked to hit both clamps
    // ****************************************
    function automatic logic signed [16:0] raw(input logic [3:0] ch);
        case (ch)
            4'h0: raw = 17'sh00000;
            4'h1: raw = 17'sh0FFFF;
            4'h2: raw = -17'sh00492;
            4'h3: raw = -17'sh01000;
            default: raw = 17'(ch * 16'h0E31);
        endcase
    endfunction : raw

    initial begin
        done = 1'b0;
        busy = 1'b0;
        cnt = 4'h0;
        held = 17'sh00000;
        value = 17'sh00000;
    end

    // ****************************************
    // Converter: value only valid in the done cycle
    // ****************************************
    always @(posedge clk) begin
        done <= 1'b0;
        value <= ~value;
        if (req.start === 1'b1) begin
            busy <= 1'b1;
            cnt <= slow ? 4'h9 : 4'h1;
            held <= raw(req.channel);
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
            value <= held;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : dicc_adc_model
`default_nettype wire

/* File: tb/dicc_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define DICC_CHK(nm, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
end
module dicc_top_tb;
    logic                    ref_clk = 1'b0;
    logic                    rst_n;
    logic                    shift_clk;
    logic                    side_toggle;
    logic                    cfg_din;
    logic                    cfg_write_en;
    logic                    slow;
    logic                    result_ready_n;
    logic                    serial_out_lane1;
    logic [15:0]             side_a_integrate_switch;
    logic [15:0]             side_b_integrate_switch;
    logic [15:0]             reference_connect_switch;
    logic [15:0]             capacitor_clear_switch;
    logic [2:0]              feedback_capacitor;
    logic [1:0]              output_word_length_sel;
    dicc_pkg::dicc_adc_req_t adc_req;
    logic                    adc_done;
    logic signed [16:0]      adc_value;
    int                      n_mismatch = 0;
    int                      compares = 0;
    int                      exp_ch = 0;
    int                      n_ref = 0;
    int                      k;

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    dicc_top dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .shift_clk(shift_clk),
        .side_toggle(side_toggle), .cfg_din(cfg_din), .cfg_write_en(cfg_write_en),
        .result_ready_n(result_ready_n), .serial_out_lane1(serial_out_lane1),
        .side_a_integrate_switch(side_a_integrate_switch),
        .side_b_integrate_switch(side_b_integrate_switch),
        .reference_connect_switch(reference_connect_switch),
        .capacitor_clear_switch(capacitor_clear_switch),
        .feedback_capacitor(feedback_capacitor),
        .output_word_length_sel(output_word_length_sel),
        .adc_req(adc_req), .adc_done(adc_done), .adc_value(adc_value)
    );

    dicc_adc_model u_adc (
        .clk(ref_clk), .req(adc_req), .slow(slow), .done(adc_done), .value(adc_value)
    );

    // ****************************************
    // Monitors
    // ****************************************
    always @(posedge ref_clk) begin
        if (adc_req.start === 1'b1) begin
            `DICC_CHK("adc_channel", 4'(exp_ch), adc_req.channel)
            `DICC_CHK("adc_side", ~side_toggle, adc_req.side_a)
            exp_ch++;
        end
        if (reference_connect_switch !== 16'h0000) begin
            n_ref++;
            `DICC_CHK("ref_group", 1'b1, reference_connect_switch inside
                {16'h000F, 16'h00F0, 16'h0F00, 16'hF000})
        end
        `DICC_CHK("clear_vs_ref", reference_connect_switch, capacitor_clear_switch)
    end

    // Ready may only move just after a master clock fall
    always @(result_ready_n) begin
        if ($time > 0)
            `DICC_CHK("ready_edge_clk", 1'b0, ref_clk)
    end

    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [15:0] code(input int ch);
        int v;
        v = int'(u_adc.raw(4'(ch))) + 32'h0492;
        if (v < 0)
            return 16'h0000;
        if (v > 32'hFFFF)
            return 16'hFFFF;
        return 16'(v);
    endfunction : code

    task automatic wait_ready();
        int i;
        for (i = 0; i < 800 && result_ready_n !== 1'b0; i++)
            @(posedge ref_clk);
        `DICC_CHK("ready_low", 1'b0, result_ready_n)
    endtask : wait_ready

    // Link clock runs only inside a frame; bit is taken before each fall
    task automatic shift_in(input int n, output logic [255:0] q);
        int i;
        q = '0;
        #7;
        for (i = 0; i < n; i++) begin
            shift_clk = 1'b1;
            #32;
            q = {q[254:0], serial_out_lane1};
            shift_clk = 1'b0;
            #32;
            if (i == 4)
                `DICC_CHK("ready_high", 1'b1, result_ready_n)
        end
    endtask : shift_in

    task automatic cfg_case(input logic [1:0] rng, input logic [1:0] res);
        logic [15:0]  c;
        logic [2:0]   ec;
        logic [255:0] q;
        int           i;
        c = {1'b1, 1'b1, res, rng, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 4'h0};
        ec = (rng == 2'h0) ? dicc_pkg::CAP_0P75PF :
             (rng == 2'h1) ? dicc_pkg::CAP_1P5PF : dicc_pkg::CAP_3PF;
        @(posedge ref_clk);
        for (i = 15; i >= 0; i--) begin
            cfg_write_en <= 1'b1;
            cfg_din <= c[i];
            @(posedge ref_clk);
        end
        cfg_write_en <= 1'b0;
        cfg_din <= 1'b0;
        wait_ready();
        `DICC_CHK("cap_sel", ec, feedback_capacitor)
        `DICC_CHK("word_sel", res, output_word_length_sel)
        shift_in(16, q);
        `DICC_CHK("readback", c, q[15:0])
    endtask : cfg_case

    task automatic sweep(input logic lvl, input logic [1:0] res, input logic slw);
        int           n;
        int           ch;
        logic [15:0]  mask;
        logic [255:0] q;
        n = (res == 2'h0) ? 16 : (res == 2'h1) ? 14 : 12;
        mask = 16'hFFFF >> (16 - n);
        exp_ch = 0;
        n_ref = 0;
        @(posedge ref_clk);
        slow <= slw;
        side_toggle <= lvl;
        repeat (6) @(posedge ref_clk);
        `DICC_CHK("side_a_sw", {16{lvl}}, side_a_integrate_switch)
        `DICC_CHK("side_b_sw", {16{~lvl}}, side_b_integrate_switch)
        wait_ready();
        `DICC_CHK("conversions", 16, exp_ch)
        `DICC_CHK("ref_cycles", 4 * int'(dicc_pkg::REF_CHARGE_CYC), n_ref)
        shift_in(16 * n, q);
        for (ch = 0; ch < 16; ch++)
            `DICC_CHK("word", code(ch) >> (16 - n),
                16'(q >> ((15 - ch) * n)) & mask)
    endtask : sweep

    task automatic print_verdict();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        shift_clk = 1'b0;
        side_toggle = 1'b0;
        cfg_din = 1'b0;
        cfg_write_en = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge ref_clk);
        `DICC_CHK("ready_rst", 1'b1, result_ready_n)
        `DICC_CHK("side_b_rst", 16'hFFFF, side_b_integrate_switch)
        `DICC_CHK("word_rst", dicc_pkg::RES_16, output_word_length_sel)
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (k = 0; k < 4; k++)
            cfg_case(2'(k), 2'(k));
        cfg_case(2'h0, 2'h0);
        sweep(1'b1, 2'h0, 1'b0);
        cfg_case(2'h1, 2'h1);
        sweep(1'b0, 2'h1, 1'b1);
        cfg_case(2'h2, 2'h2);
        sweep(1'b1, 2'h2, 1'b0);
        print_verdict();
    end

    // Whole run needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule : dicc_top_tb
`default_nettype wire
